/* hw/mtw_timer_unit.sv */
// timer unit: prescaler, timers 1-4, watchdog flag, lcd divider, axi4-lite slave
// assumes main/sub clock enables and pin inputs are synchronous to aclk
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "mtw_defs.svh"

// Notes on behaviour
// - prescaler divides system clock by 6 or 12
// - prescaler held reset while run bit low
// - timer 1 load writes counter and reload
// - timer 1 underflow sets flag and reloads
// - pin a toggles on timer 1 underflow
// - timer 2 source select and run bit
// - zero-cross flag can start timer 2
// - zero-cross mode counts only while flag set
// - timer 2 underflow sets flag and reloads
// - pin b toggles on timer 2 underflow
// - timer 3 source select and run bit
// - timer 3 flags every 256, taps 16
// - timer 3 run clear clears counter
// - timers 3 and 4 run in power-down
// - timer 4 three load kinds
// - timer 4 source select and run bit
// - timer 4 underflow sets flag and reloads
// - second underflow with flag set forces reset
// - watchdog enable, software clears flag in time
// - request flags set on underflow, cleared on service
// - lcd timer 4-bit with reload latch
module mtw_timer_unit
    import mtw_pkg::*;
(
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // axi4-lite slave
    input  wire logic [11:0]        s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [11:0]        s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    // clock enables and status inputs
    input  wire logic               main_clk_en,
    input  wire logic               sub_clk_en,
    input  wire logic               zero_cross_start_flag,
    input  wire logic               power_down_one,
    input  wire logic               timer_io_pin_b_in,
    input  wire logic               int_service_t1,
    input  wire logic               int_service_t2,
    input  wire logic               int_service_t3,
    input  wire logic               int_service_t4,
    // outputs
    output mtw_pkg::mtw_flags_t     flags,
    output mtw_pkg::mtw_pins_t      pins,
    output logic                    lcd_clock,
    output logic                    watchdog_reset
);
    import mtw_pkg::*;

    // four-way selection shared by timer 2 and timer 4 sources
    function automatic logic pick4(input logic [1:0] sel, input logic a, input logic b,
                                   input logic c, input logic d);
        case (sel)
            MTW_SRC_0: pick4 = a;
            MTW_SRC_1: pick4 = b;
            MTW_SRC_2: pick4 = c;
            default:   pick4 = d;
        endcase
    endfunction

    // control registers
    logic [3:0] timer_ctrl_one;              // pin a, t1 run, divide, prescaler run
    logic [3:0] timer_ctrl_two;              // t2 source, zero-cross mode, pin b
    logic [3:0] timer_ctrl_three;            // t3 source/run, lcd source/run
    logic [3:0] timer_ctrl_four;             // t4 source, watchdog enable
    logic [2:0] timer_ctrl_five;             // t2 run, t4 run, bit 2 spare
    logic       clock_select_register;       // 0 main clock, 1 sub clock

    // counters and reload registers
    logic [7:0] t1_cnt;
    logic [7:0] timer_one_reload;
    logic [7:0] t2_cnt;
    logic [7:0] timer_two_reload;
    logic [7:0] t3_cnt;
    logic [7:0] t4_cnt;
    logic [7:0] timer_four_reload;
    logic [3:0] lcd_cnt;
    logic [3:0] lcd_reload;
    logic [3:0] pre_cnt;                     // prescaler divide counter
    logic       t1_loaded;                   // data set since reset
    logic       t2_loaded;
    logic       t4_loaded;
    logic       pin_b_prev;                  // external count edge detect

    // axi bookkeeping
    logic        aw_held;
    logic        w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    // write decode, one strobe per register except the read-only timer 3 count
    wire        do_write  = aw_held && w_held && !s_axi_bvalid;
    wire        low_lane  = w_strb[0];
    wire        wr_ok     = do_write && low_lane;
    wire        wr_c1     = wr_ok && (aw_addr == `MTW_OFF_CTRL_ONE);
    wire        wr_c2     = wr_ok && (aw_addr == `MTW_OFF_CTRL_TWO);
    wire        wr_c3     = wr_ok && (aw_addr == `MTW_OFF_CTRL_THREE);
    wire        wr_c4     = wr_ok && (aw_addr == `MTW_OFF_CTRL_FOUR);
    wire        wr_c5     = wr_ok && (aw_addr == `MTW_OFF_CTRL_FIVE);
    wire        load_timer_one_both        = wr_ok && (aw_addr == `MTW_OFF_T1_BOTH);
    wire        load_timer_two_both        = wr_ok && (aw_addr == `MTW_OFF_T2_BOTH);
    wire        load_timer_four_both       = wr_ok && (aw_addr == `MTW_OFF_T4_BOTH);
    wire        load_timer_four_counter_only = wr_ok && (aw_addr == `MTW_OFF_T4_CNT);
    wire        load_timer_four_reload_only  = wr_ok && (aw_addr == `MTW_OFF_T4_RLD);
    wire        load_lcd_divider           = wr_ok && (aw_addr == `MTW_OFF_LCD);
    wire        wr_flags  = wr_ok && (aw_addr == `MTW_OFF_FLAGS);
    wire        wr_clksel = wr_ok && (aw_addr == `MTW_OFF_CLK_SEL);
    wire        wr_mapped = (aw_addr == `MTW_OFF_CTRL_ONE) || (aw_addr == `MTW_OFF_CTRL_TWO)
                         || (aw_addr == `MTW_OFF_CTRL_THREE) || (aw_addr == `MTW_OFF_CTRL_FOUR)
                         || (aw_addr == `MTW_OFF_CTRL_FIVE) || (aw_addr == `MTW_OFF_T1_BOTH)
                         || (aw_addr == `MTW_OFF_T2_BOTH) || (aw_addr == `MTW_OFF_T4_BOTH)
                         || (aw_addr == `MTW_OFF_T4_CNT) || (aw_addr == `MTW_OFF_T4_RLD)
                         || (aw_addr == `MTW_OFF_LCD) || (aw_addr == `MTW_OFF_FLAGS)
                         || (aw_addr == `MTW_OFF_CLK_SEL);
    wire [7:0]  wbyte     = w_data[7:0];
    // write-one-to-clear on the flags word stands in for the skip instruction
    wire [3:0]  flag_clr  = wr_flags ? wbyte[3:0] : 4'h0;
    wire        watchdog_clear_instr = wr_flags && wbyte[`MTW_BF_WDF];

    // system clock enable chosen by the clock select register
    wire sys_clk_en = clock_select_register ? sub_clk_en : main_clk_en;

    // prescaler stopped and held while run bit low
    wire pre_run    = timer_ctrl_one[`MTW_B1_PRE_RUN] && !power_down_one;
    // terminal count 6 or 12 per divide select
    wire [3:0] pre_term = timer_ctrl_one[`MTW_B1_DIV_SEL] ? `MTW_PRE_DIV_HI : `MTW_PRE_DIV_LO;
    wire pre_wrap   = pre_run && sys_clk_en && (pre_cnt == pre_term - 4'h1);
    wire prescaler_out_clock = pre_wrap;

    // external count input, rising edge of pin b
    wire ext_tick   = timer_io_pin_b_in && !pin_b_prev;

    // timer 1 counts prescaler output after load and run
    wire t1_en      = t1_loaded && timer_ctrl_one[`MTW_B1_T1_RUN] && !power_down_one;
    wire t1_tick    = t1_en && prescaler_out_clock;
    // underflow is the pulse after zero
    wire t1_uf      = t1_tick && (t1_cnt == `MTW_ZERO8);

    // timer 2 source from control two bits 0 and 1
    wire t2_src     = pick4(timer_ctrl_two[1:0], main_clk_en, t1_uf, prescaler_out_clock,
                            ext_tick);
    // zero-cross flag replaces the run bit as trigger
    // counts only while the flag stays set
    wire t2_gate    = timer_ctrl_two[`MTW_B2_ZC_MODE] ? zero_cross_start_flag
                                                      : timer_ctrl_five[`MTW_B5_T2_RUN];
    wire t2_tick    = t2_loaded && t2_gate && !power_down_one && t2_src;
    wire t2_uf      = t2_tick && (t2_cnt == `MTW_ZERO8);

    // timer 3 source sub clock or timer 2 underflow
    // no power-down gate on timers 3 and 4
    wire t3_run     = timer_ctrl_three[`MTW_B3_T3_RUN];
    wire t3_tick    = t3_run && (timer_ctrl_three[`MTW_B3_T3_SRC] ? t2_uf : sub_clk_en);
    // divide by 256 underflow and divide by 16 tap
    wire t3_uf      = t3_tick && (t3_cnt == `MTW_ZERO8);
    wire t3_mid     = t3_tick && (t3_cnt[3:0] == `MTW_ZERO4);

    // timer 4 source from control four bits 0 and 1
    wire t4_src     = pick4(timer_ctrl_four[1:0], main_clk_en, t3_uf, t2_uf,
                            prescaler_out_clock);
    wire t4_tick    = t4_loaded && timer_ctrl_five[`MTW_B5_T4_RUN] && t4_src;
    wire t4_uf      = t4_tick && (t4_cnt == `MTW_ZERO8);

    // lcd divider source: timer 3 tap or underflow
    wire lcd_tick   = timer_ctrl_three[`MTW_B3_LCD_RUN]
                   && (timer_ctrl_three[`MTW_B3_LCD_SRC] ? t3_uf : t3_mid);
    wire lcd_uf     = lcd_tick && (lcd_cnt == `MTW_ZERO4);

    // watchdog trips on underflow with flag still set
    wire wd_trip    = t4_uf && flags.watchdog_armed_flag
                   && timer_ctrl_four[`MTW_B4_WD_EN];

    // read decode
    // counts read raw, software must stop the timer first
    wire [7:0] rd_flags = {3'h0, flags.watchdog_armed_flag, flags.timer_four_request_flag,
                           flags.timer_three_request_flag, flags.timer_two_request_flag,
                           flags.timer_one_request_flag};
    logic [7:0] rd_byte;
    logic       rd_hit;
    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = `MTW_ZERO8;
        unique case (s_axi_araddr)
            `MTW_OFF_CTRL_ONE:   rd_byte = {4'h0, timer_ctrl_one};
            `MTW_OFF_CTRL_TWO:   rd_byte = {4'h0, timer_ctrl_two};
            `MTW_OFF_CTRL_THREE: rd_byte = {4'h0, timer_ctrl_three};
            `MTW_OFF_CTRL_FOUR:  rd_byte = {4'h0, timer_ctrl_four};
            `MTW_OFF_CTRL_FIVE:  rd_byte = {5'h00, timer_ctrl_five};
            `MTW_OFF_T1_BOTH:    rd_byte = t1_cnt;
            `MTW_OFF_T2_BOTH:    rd_byte = t2_cnt;
            `MTW_OFF_T4_BOTH:    rd_byte = t4_cnt;
            `MTW_OFF_T4_CNT:     rd_byte = t4_cnt;
            `MTW_OFF_T4_RLD:     rd_byte = timer_four_reload;
            `MTW_OFF_LCD:        rd_byte = {4'h0, lcd_cnt};
            `MTW_OFF_FLAGS:      rd_byte = rd_flags;
            `MTW_OFF_CLK_SEL:    rd_byte = {7'h00, clock_select_register};
            `MTW_OFF_T3_CNT:     rd_byte = t3_cnt;
            default:             rd_hit  = 1'b0;   // unmapped: slverr, zero data
        endcase
    end

    // axi write channel: hold address and data until both are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 12'h000;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `MTW_RESP_OKAY;
        end else begin
            // ready only while the slot is empty, so one write at a time
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? `MTW_RESP_OKAY : `MTW_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi read channel: address taken, data one cycle later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `MTW_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && !s_axi_arvalid ? 1'b1
                           : (!s_axi_rvalid && !(s_axi_arvalid && s_axi_arready));
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rd_byte};
                s_axi_rresp  <= rd_hit ? `MTW_RESP_OKAY : `MTW_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // control registers
    // reset stops every counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_ctrl_one        <= `MTW_CTRL_RST;
            timer_ctrl_two        <= `MTW_CTRL_RST;
            timer_ctrl_three      <= `MTW_CTRL_RST;
            timer_ctrl_four       <= `MTW_CTRL_RST;
            timer_ctrl_five       <= 3'h0;
            clock_select_register <= 1'b0;
        end else begin
            if (wr_c1) timer_ctrl_one   <= wbyte[3:0];
            if (wr_c2) timer_ctrl_two   <= wbyte[3:0];
            if (wr_c3) timer_ctrl_three <= wbyte[3:0];
            if (wr_c4) timer_ctrl_four  <= wbyte[3:0];
            if (wr_c5) timer_ctrl_five  <= wbyte[2:0];
            if (wr_clksel) clock_select_register <= wbyte[0];
        end
    end

    // prescaler
    always_ff @(posedge aclk) begin
        if (!aresetn || !pre_run) begin
            pre_cnt <= `MTW_ZERO4;
        end else if (sys_clk_en) begin
            pre_cnt <= pre_wrap ? `MTW_ZERO4 : pre_cnt + 4'h1;
        end
    end

    // timer 1 and timer 2 counters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            t1_cnt           <= `MTW_ZERO8;
            timer_one_reload <= `MTW_ZERO8;
            t1_loaded        <= 1'b0;
            t2_cnt           <= `MTW_ZERO8;
            timer_two_reload <= `MTW_ZERO8;
            t2_loaded        <= 1'b0;
            pin_b_prev       <= 1'b0;
        end else begin
            pin_b_prev <= timer_io_pin_b_in;
            // one write sets counter and reload
            if (load_timer_one_both) begin
                t1_cnt           <= wbyte;
                timer_one_reload <= wbyte;
                t1_loaded        <= 1'b1;
            end else if (t1_tick) begin
                // reload on underflow, divide by n+1
                t1_cnt <= t1_uf ? timer_one_reload : t1_cnt - 8'h01;
            end
            if (load_timer_two_both) begin
                t2_cnt           <= wbyte;
                timer_two_reload <= wbyte;
                t2_loaded        <= 1'b1;
            end else if (t2_tick) begin
                t2_cnt <= t2_uf ? timer_two_reload : t2_cnt - 8'h01;
            end
        end
    end

    // timer 3 fixed divider
    always_ff @(posedge aclk) begin
        if (!aresetn || !t3_run) begin
            // run clear clears counter, taps stop
            t3_cnt <= `MTW_ZERO8;
        end else if (t3_tick) begin
            t3_cnt <= t3_cnt - 8'h01;
        end
    end

    // timer 4 with three load kinds
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            t4_cnt            <= `MTW_ZERO8;
            timer_four_reload <= `MTW_ZERO8;
            t4_loaded         <= 1'b0;
        end else begin
            if (load_timer_four_both || load_timer_four_reload_only) begin
                timer_four_reload <= wbyte;
            end
            if (load_timer_four_both || load_timer_four_counter_only) begin
                t4_cnt    <= wbyte;
                t4_loaded <= 1'b1;
            end else if (t4_tick) begin
                t4_cnt <= t4_uf ? timer_four_reload : t4_cnt - 8'h01;
            end
        end
    end

    // lcd divider: 4-bit counter plus divide by two
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lcd_cnt    <= `MTW_ZERO4;
            lcd_reload <= `MTW_ZERO4;
            lcd_clock  <= 1'b0;
        end else begin
            // one write sets counter and latch
            if (load_lcd_divider) begin
                lcd_cnt    <= wbyte[3:0];
                lcd_reload <= wbyte[3:0];
            end else if (lcd_tick) begin
                lcd_cnt <= lcd_uf ? lcd_reload : lcd_cnt - 4'h1;
            end
            if (lcd_uf) lcd_clock <= !lcd_clock;
        end
    end

    // request flags and watchdog; a set in the clear cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags          <= '0;
            watchdog_reset <= 1'b0;
        end else begin
            // set on underflow, cleared by service or skip
            flags.timer_one_request_flag <= t1_uf
                || (flags.timer_one_request_flag && !flag_clr[0] && !int_service_t1);
            flags.timer_two_request_flag <= t2_uf
                || (flags.timer_two_request_flag && !flag_clr[1] && !int_service_t2);
            flags.timer_three_request_flag <= t3_uf
                || (flags.timer_three_request_flag && !flag_clr[2] && !int_service_t3);
            flags.timer_four_request_flag <= t4_uf
                || (flags.timer_four_request_flag && !flag_clr[3] && !int_service_t4);
            // flag set by timer 4 underflow
            // clear instruction, armed only when enabled
            flags.watchdog_armed_flag <= (t4_uf && timer_ctrl_four[`MTW_B4_WD_EN])
                || (flags.watchdog_armed_flag && !watchdog_clear_instr);
            // one-cycle request to the system reset logic
            watchdog_reset <= wd_trip;
        end
    end

    // timer pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins <= '0;
        end else begin
            // pin a is timer 1 underflow halved
            if (!timer_ctrl_one[`MTW_B1_PIN_A]) pins.timer_out_pin_a <= 1'b0;
            else if (t1_uf) pins.timer_out_pin_a <= !pins.timer_out_pin_a;
            // pin b is timer 2 underflow halved
            pins.timer_io_pin_b_oe <= timer_ctrl_two[`MTW_B2_PIN_B];
            if (!timer_ctrl_two[`MTW_B2_PIN_B]) pins.timer_io_pin_b_out <= 1'b0;
            else if (t2_uf) pins.timer_io_pin_b_out <= !pins.timer_io_pin_b_out;
        end
    end

endmodule

/* common/mtw_defs.svh */
// register offsets, field positions, reset values and counts for the timer unit
// assumes a 32-bit AXI4-Lite register bus, one aligned word per register
`ifndef MTW_DEFS_SVH
`define MTW_DEFS_SVH

// byte addresses of the registers
`define MTW_OFF_CTRL_ONE    12'h000
`define MTW_OFF_CTRL_TWO    12'h004
`define MTW_OFF_CTRL_THREE  12'h008
`define MTW_OFF_CTRL_FOUR   12'h00c
`define MTW_OFF_CTRL_FIVE   12'h010
`define MTW_OFF_T1_BOTH     12'h014
`define MTW_OFF_T2_BOTH     12'h018
`define MTW_OFF_T4_BOTH     12'h01c
`define MTW_OFF_T4_CNT      12'h020
`define MTW_OFF_T4_RLD      12'h024
`define MTW_OFF_LCD         12'h028
`define MTW_OFF_FLAGS       12'h02c
`define MTW_OFF_CLK_SEL     12'h030
`define MTW_OFF_T3_CNT      12'h034

// field positions
`define MTW_B1_PIN_A        0
`define MTW_B1_T1_RUN       1
`define MTW_B1_DIV_SEL      2
`define MTW_B1_PRE_RUN      3
`define MTW_B2_ZC_MODE      2
`define MTW_B2_PIN_B        3
`define MTW_B3_T3_SRC       0
`define MTW_B3_T3_RUN       1
`define MTW_B3_LCD_SRC      2
`define MTW_B3_LCD_RUN      3
`define MTW_B4_WD_EN        2
`define MTW_B5_T2_RUN       0
`define MTW_B5_T4_RUN       1
`define MTW_BF_WDF          4

// counts and constants
`define MTW_PRE_DIV_LO      4'h6
`define MTW_PRE_DIV_HI      4'hc
`define MTW_ZERO8           8'h00
`define MTW_ZERO4           4'h0
`define MTW_CTRL_RST        4'h0
`define MTW_RESP_OKAY       2'b00
`define MTW_RESP_SLVERR     2'b10

`endif

/* common/mtw_pkg.sv */
// types shared by the timer unit and its bench
// constants live in mtw_defs.svh
package mtw_pkg;

    // four-way count source choice, meaning depends on the timer
    typedef enum logic [1:0] {
        MTW_SRC_0 = 2'b00,
        MTW_SRC_1 = 2'b01,
        MTW_SRC_2 = 2'b10,
        MTW_SRC_3 = 2'b11
    } mtw_src_t;

    // request and watchdog flags as seen by software
    typedef struct packed {
        logic watchdog_armed_flag;
        logic timer_four_request_flag;
        logic timer_three_request_flag;
        logic timer_two_request_flag;
        logic timer_one_request_flag;
    } mtw_flags_t;

    // timer pins toward the port logic
    typedef struct packed {
        logic timer_out_pin_a;
        logic timer_io_pin_b_out;
        logic timer_io_pin_b_oe;
    } mtw_pins_t;

endpackage

/* sim/mtw_timer_unit_asserts.sv */
// port checks for the timer unit: bus handshake and watchdog pulse
// bound onto mtw_timer_unit, one aclk domain
`timescale 1ns/1ps
module mtw_chk
    import mtw_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic watchdog_reset,
    input mtw_flags_t     flags
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both write halves taken in one cycle
    wire go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("rvalid dropped");
    AST_AWBLK: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw early");
    AST_ARBLK: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar early");
    AST_WRLAT: assert property (go |-> ##[1:3] s_axi_bvalid) else $error("no bvalid");
    AST_RDLAT: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("no rvalid");
    AST_WDCAUSE: assert property (watchdog_reset |-> $past(flags.watchdog_armed_flag))
        else $error("reset without armed flag");
    AST_WDPULSE: assert property (watchdog_reset |=> !watchdog_reset)
        else $error("reset pulse too long");
    cover property (go);
    cover property (watchdog_reset);
    cover property (flags.timer_three_request_flag);
endmodule
bind mtw_timer_unit mtw_chk u_chk (.*);

/* sim/tb.sv */
// self-checking bench for the timer unit
// clock enables held high, so every aclk edge is a count tick
`timescale 1ns/1ps
`include "mtw_defs.svh"
`define CHK(s, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %s exp %0h got %0h", s, e, g); end end
module tb;
    import mtw_pkg::*;
    logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
    logic s_axi_arvalid = '0, s_axi_rready = '0, main_clk_en = '1, sub_clk_en = '1;
    logic zero_cross_start_flag = '0, power_down_one = '0, timer_io_pin_b_in = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic watchdog_reset, lcd_clock, p;
    logic [1:0] s_axi_bresp, s_axi_rresp, rrs;
    logic [3:0] svc = '0, s_axi_wstrb = 4'hf;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdv;
    mtw_flags_t flags;
    mtw_pins_t pins;
    wire int_service_t1 = svc[0], int_service_t2 = svc[1];
    wire int_service_t3 = svc[2], int_service_t4 = svc[3];
    wire [6:0] obs = {lcd_clock, watchdog_reset, flags};
    int fails = 0, check_count = 0, n;
    mtw_timer_unit dut (.*);
    always #5 aclk = ~aclk;
    // bus write, both channels offered together
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= d;
        s_axi_awvalid <= '1; s_axi_wvalid <= '1; s_axi_bready <= '1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= '0;
            if (s_axi_wready) s_axi_wvalid <= '0;
        end while (!s_axi_bvalid);
        s_axi_bready <= '0;
    endtask
    task rd(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= '1; s_axi_rready <= '1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= '0;
        end while (!s_axi_rvalid);
        rdv = s_axi_rdata; rrs = s_axi_rresp; s_axi_rready <= '0;
    endtask
    // bounded wait for one observed bit
    task wt(input int b); int i;
        for (i = 0; i < 600 && obs[b] !== 1'h1; i++) @(posedge aclk);
    endtask
    // service the flag, then count edges to its next rise; 600 means never
    task meas(input int b);
        wt(b); svc[b] <= '1; n = 0;
        do begin
            @(posedge aclk); svc[b] <= '0; n++;
        end while (n < 600 && !(n > 1 && obs[b] === 1'h1));
    endtask
    task t_one;
        wr(`MTW_OFF_T1_BOTH, 32'h2); wr(`MTW_OFF_CTRL_ONE, 32'hb);
        meas(0); p = pins.timer_out_pin_a; meas(0);
        `CHK("t1_div6", 18, n)
        `CHK("pin_a", ~p, pins.timer_out_pin_a)
        // ratio changed only while the prescaler is stopped
        wr(`MTW_OFF_CTRL_ONE, 32'h2); wr(`MTW_OFF_T1_BOTH, 32'h0);
        wr(`MTW_OFF_CTRL_ONE, 32'he); meas(0);
        `CHK("t1_div12", 12, n)
        wr(`MTW_OFF_CTRL_ONE, 32'h2); meas(0);
        `CHK("pre_stop", 600, n)
    endtask
    task t_two;
        wr(`MTW_OFF_T2_BOTH, 32'h4); wr(`MTW_OFF_CTRL_TWO, 32'h8);
        wr(`MTW_OFF_CTRL_FIVE, 32'h1);
        meas(1); p = pins.timer_io_pin_b_out; meas(1);
        `CHK("t2_div5", 5, n)
        `CHK("pin_b", ~p, pins.timer_io_pin_b_out)
        `CHK("pin_b_oe", 1'h1, pins.timer_io_pin_b_oe)
        wr(`MTW_OFF_CTRL_FIVE, 32'h0); wr(`MTW_OFF_CTRL_TWO, 32'h4); meas(1);
        `CHK("zc_idle", 600, n)
        zero_cross_start_flag <= '1; meas(1);
        `CHK("zc_run", 5, n)
        zero_cross_start_flag <= '0;
    endtask
    task t_three;
        // core halted while timer 3 counts
        power_down_one <= '1;
        wr(`MTW_OFF_CTRL_THREE, 32'h2); meas(2);
        `CHK("t3_div256", 256, n)
        // lcd divider on the /16 tap, reload 1: half period of 32 ticks
        wr(`MTW_OFF_LCD, 32'h1); wr(`MTW_OFF_CTRL_THREE, 32'ha); wt(6); n = 0;
        while (obs[6] === 1'h1 && n < 600) begin
            @(posedge aclk); n++;
        end
        `CHK("lcd_half", 32, n)
        power_down_one <= '0;
        wr(`MTW_OFF_CTRL_THREE, 32'h0); rd(`MTW_OFF_T3_CNT);
        `CHK("t3_clear", 32'h0, rdv)
    endtask
    task t_four;
        wr(`MTW_OFF_T4_BOTH, 32'h9); wr(`MTW_OFF_T4_CNT, 32'h5);
        rd(`MTW_OFF_T4_CNT);
        `CHK("t4_cnt", 32'h5, rdv)
        rd(`MTW_OFF_T4_RLD);
        `CHK("t4_rld", 32'h9, rdv)
        rd(12'h100);
        `CHK("unmapped", `MTW_RESP_SLVERR, rrs)
        wr(`MTW_OFF_CTRL_FIVE, 32'h2); meas(3);
        `CHK("t4_div10", 10, n)
    endtask
    task t_wd;
        wr(`MTW_OFF_CTRL_FOUR, 32'h4); wt(4);
        `CHK("wd_flag", 1'h1, flags.watchdog_armed_flag)
        wt(5);
        `CHK("wd_reset", 1'h1, watchdog_reset)
        // every counter stopped, so the clear cannot race a set
        wr(`MTW_OFF_CTRL_FIVE, 32'h0); wr(`MTW_OFF_FLAGS, 32'h1f); rd(`MTW_OFF_FLAGS);
        `CHK("wd_clear", 32'h0, rdv)
    endtask
    task end_sim;
        if (fails == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= '1;
        `CHK("flags", 5'h0, flags)
        `CHK("pins", 3'h0, pins)
        t_one; t_two; t_three; t_four; t_wd;
        end_sim;
    end
    // hang guard, well past the few thousand cycles the tests need
    initial begin
        #300000;
        fails++;
        end_sim;
    end
endmodule
